// [core/ebs_pkg.sv]
// Shared constants for the external brake sequencer: register map,
// field layouts, reset values, state codes and timing counts.
// Assumes a 100 MHz system clock.
package ebs_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    // One step of every wait setting, 0.01 s
    localparam int unsigned WAIT_LSB_NS = 10000000;
    localparam int unsigned TICK_CYCLES = WAIT_LSB_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 24;
    // Waits run 0.00 to 5.00 s in 0.01 s steps
    localparam logic [8:0] WAIT_MAX = 9'h1F4;

    // ----------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAIT_REL = 8'h04;
    localparam logic [7:0] OFS_WAIT_ACC = 8'h08;
    localparam logic [7:0] OFS_WAIT_STP = 8'h0C;
    localparam logic [7:0] OFS_WAIT_CNF = 8'h10;
    localparam logic [7:0] OFS_REL_FREQ = 8'h14;
    localparam logic [7:0] OFS_REL_CUR = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_INT_STAT = 8'h20;
    localparam logic [7:0] OFS_INT_MASK = 8'h24;

    // CTRL fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_CLR_BIT = 1;
    // Interrupt fields
    localparam int unsigned INT_REL_BIT = 0;
    localparam int unsigned INT_ENG_BIT = 1;
    localparam int unsigned INT_FLT_BIT = 2;
    localparam int unsigned INT_W = 3;

    // Reset values
    localparam logic [15:0] REL_FREQ_RST = 16'h0000;
    // Rated current, in percent of rating
    localparam logic [7:0] REL_CUR_RST = 8'h64;
    // Frequency is in 0.01 Hz units, 400.0 Hz at most
    localparam logic [15:0] REL_FREQ_MAX = 16'h9C40;
    localparam logic [7:0] REL_CUR_MAX = 8'hC8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_WAIT_FREQ = 4'h1,
        ST_REL_DLY = 4'h2,
        ST_CONF_ON = 4'h3,
        ST_ACC_DLY = 4'h4,
        ST_RUN = 4'h5,
        ST_CONF_OFF = 4'h6,
        ST_STP_DLY = 4'h7,
        ST_FAULT = 4'h8
    } ebs_state_e;

endpackage

// [core/ebs_tmr_if.sv]
// Link between the sequencer and its wait timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ebs_tmr_if;
    logic start;
    logic [8:0] units;
    logic done;
    modport mgr (output start, output units, input done);
    modport tmr (input start, input units, output done);
endinterface
`default_nettype wire

// [core/ebs_sync.sv]
// Two-stage synchroniser for one pin level.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ebs_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic level
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            level <= 1'b0;
        end else begin
            meta_q <= pin;
            level <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [core/ebs_timer.sv]
// Wait timer counting in 0.01 s steps.
// Assumes start is a one-cycle pulse; done stays high until next start.
`timescale 1ns/1ps
`default_nettype none
module ebs_timer #(
    parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    ebs_tmr_if.tmr tif
);
    import ebs_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    logic [TICK_W-1:0] tick_q;
    logic [8:0] cnt_q;
    logic run_q;
    logic done_q;

    assign tif.done = done_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_q <= '0;
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else if (tif.start) begin
            tick_q <= '0;
            cnt_q <= tif.units;
            run_q <= 1'b1;
            done_q <= 1'b0;
        end else if (run_q) begin
            if (cnt_q == 9'h000) begin
                run_q <= 1'b0;
                done_q <= 1'b1;
            end else if (tick_q == TICK_LAST) begin
                tick_q <= '0;
                cnt_q <= cnt_q - 9'h001;
            end else begin
                tick_q <= tick_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [core/ebs_top.sv]
// External brake sequencer with APB registers and one interrupt.
// Assumes drive frequency and current come from logic on clk;
// the brake confirmation contact is an asynchronous pin.
// Function
// [R1] Release brake only while driving the motor
// [R2] Release output, confirm input, separate fault output
// [R3] Release delay after reaching release frequency
// [R4] Hold frequency after confirmation, then accelerate
// [R5] After confirmation drops, wait, then stop
// [R6] Missing confirmation within window trips fault
// [R7] Programmable release frequency threshold starts delay
// [R8] Release only above minimum current
// [R9] Disabled: no release, no fault, no waiting
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ebs_top #(
    parameter int unsigned TICK_CYCLES = ebs_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_cmd,
    input wire logic [15:0] out_freq,
    input wire logic [7:0] out_current_pct,
    input wire logic brake_confirm_in,
    output logic brake_release_out,
    output logic brake_fault_out,
    output logic accel_hold_out,
    output logic decel_hold_out,
    output logic irq
);
    import ebs_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic en_q;
    logic [8:0] wait_rel_q, wait_acc_q, wait_stp_q, wait_cnf_q;
    logic [15:0] rel_freq_q;
    logic [7:0] rel_cur_q;
    logic [INT_W-1:0] int_stat_q, int_mask_q, ev;
    logic wr, rd, mapped, clr_fault;
    ebs_state_e state_q, state_d;
    logic conf_s;
    logic rel_d, flt_d;

    ebs_tmr_if tif ();

    // [R2] Confirmation input
    ebs_sync u_ebs_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(brake_confirm_in),
        .level(conf_s)
    );

    ebs_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_ebs_timer (
        .clk(clk),
        .rst_b(rst_b),
        .tif(tif)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign clr_fault = wr && (paddr == OFS_CTRL) && pwdata[CTRL_CLR_BIT];

    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_WAIT_REL, OFS_WAIT_ACC, OFS_WAIT_STP, OFS_WAIT_CNF,
            OFS_REL_FREQ, OFS_REL_CUR, OFS_STATUS, OFS_INT_STAT,
            OFS_INT_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_CTRL: prdata <= {31'h0, en_q};
                OFS_WAIT_REL: prdata <= {23'h0, wait_rel_q};
                OFS_WAIT_ACC: prdata <= {23'h0, wait_acc_q};
                OFS_WAIT_STP: prdata <= {23'h0, wait_stp_q};
                OFS_WAIT_CNF: prdata <= {23'h0, wait_cnf_q};
                OFS_REL_FREQ: prdata <= {16'h0000, rel_freq_q};
                OFS_REL_CUR: prdata <= {24'h000000, rel_cur_q};
                OFS_STATUS: prdata <= {23'h0, conf_s, brake_fault_out,
                    brake_release_out, decel_hold_out, accel_hold_out, state_q};
                OFS_INT_STAT: prdata <= {29'h0, int_stat_q};
                OFS_INT_MASK: prdata <= {29'h0, int_mask_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Out-of-range settings clip to their maximum
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_q <= 1'b0;
            wait_rel_q <= 9'h000;
            wait_acc_q <= 9'h000;
            wait_stp_q <= 9'h000;
            wait_cnf_q <= 9'h000;
            rel_freq_q <= REL_FREQ_RST;
            rel_cur_q <= REL_CUR_RST;
            int_mask_q <= '0;
        end else if (wr) begin
            case (paddr)
                OFS_CTRL: en_q <= pwdata[CTRL_EN_BIT];
                OFS_WAIT_REL: wait_rel_q <= (pwdata[8:0] > WAIT_MAX) ? WAIT_MAX : pwdata[8:0];
                OFS_WAIT_ACC: wait_acc_q <= (pwdata[8:0] > WAIT_MAX) ? WAIT_MAX : pwdata[8:0];
                OFS_WAIT_STP: wait_stp_q <= (pwdata[8:0] > WAIT_MAX) ? WAIT_MAX : pwdata[8:0];
                OFS_WAIT_CNF: wait_cnf_q <= (pwdata[8:0] > WAIT_MAX) ? WAIT_MAX : pwdata[8:0];
                // [R7] Release frequency setting
                OFS_REL_FREQ: rel_freq_q <= (pwdata[15:0] > REL_FREQ_MAX) ?
                    REL_FREQ_MAX : pwdata[15:0];
                // [R8] Release current setting
                OFS_REL_CUR: rel_cur_q <= (pwdata[7:0] > REL_CUR_MAX) ?
                    REL_CUR_MAX : pwdata[7:0];
                OFS_INT_MASK: int_mask_q <= pwdata[INT_W-1:0];
                default: en_q <= en_q;
            endcase
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (run_cmd) begin
                    state_d = ST_WAIT_FREQ;
                end
            end
            ST_WAIT_FREQ: begin
                if (!run_cmd) begin
                    state_d = ST_IDLE;
                // [R7] Threshold starts delay
                end else if (out_freq >= rel_freq_q) begin
                    state_d = ST_REL_DLY;
                end
            end
            ST_REL_DLY: begin
                if (!run_cmd) begin
                    state_d = ST_IDLE;
                end else if (out_freq < rel_freq_q) begin
                    state_d = ST_WAIT_FREQ;
                // [R3] Release after delay, [R1] [R8] only when powering motor
                end else if (tif.done && (out_current_pct > rel_cur_q)) begin
                    state_d = ST_CONF_ON;
                end
            end
            ST_CONF_ON: begin
                if (conf_s) begin
                    state_d = ST_ACC_DLY;
                // [R6] Confirmation timeout
                end else if (tif.done) begin
                    state_d = ST_FAULT;
                end else if (!run_cmd) begin
                    state_d = ST_CONF_OFF;
                end
            end
            ST_ACC_DLY: begin
                if (!run_cmd) begin
                    state_d = ST_CONF_OFF;
                // [R4] Hold then accelerate
                end else if (tif.done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_cmd) begin
                    state_d = ST_CONF_OFF;
                end
            end
            ST_CONF_OFF: begin
                if (!conf_s) begin
                    state_d = ST_STP_DLY;
                // [R6] Engage timeout
                end else if (tif.done) begin
                    state_d = ST_FAULT;
                end
            end
            ST_STP_DLY: begin
                // [R5] Wait before stopping
                if (tif.done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_FAULT: begin
                if (clr_fault) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // [R9] Disabled forces idle
        if (!en_q) begin
            state_d = ST_IDLE;
        end
    end

    // A timer start on every state change; the idle value is unused
    assign tif.start = (state_d != state_q);

    always_comb begin
        case (state_d)
            ST_REL_DLY: tif.units = wait_rel_q;
            ST_ACC_DLY: tif.units = wait_acc_q;
            ST_STP_DLY: tif.units = wait_stp_q;
            ST_CONF_ON, ST_CONF_OFF: tif.units = wait_cnf_q;
            default: tif.units = 9'h000;
        endcase
    end

    assign rel_d = (state_d == ST_CONF_ON) || (state_d == ST_ACC_DLY)
        || (state_d == ST_RUN);
    assign flt_d = (state_d == ST_FAULT);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // [R2] Brake outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            brake_release_out <= 1'b0;
            brake_fault_out <= 1'b0;
            accel_hold_out <= 1'b0;
            decel_hold_out <= 1'b0;
        end else begin
            brake_release_out <= rel_d;
            brake_fault_out <= flt_d;
            accel_hold_out <= (state_d == ST_WAIT_FREQ) || (state_d == ST_REL_DLY)
                || (state_d == ST_CONF_ON) || (state_d == ST_ACC_DLY);
            decel_hold_out <= (state_d == ST_CONF_OFF) || (state_d == ST_STP_DLY);
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    assign ev[INT_REL_BIT] = rel_d && !brake_release_out;
    assign ev[INT_ENG_BIT] = !rel_d && brake_release_out;
    assign ev[INT_FLT_BIT] = flt_d && !brake_fault_out;

    // Only bits captured by the read are cleared; events after its setup survive
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            int_stat_q <= '0;
        end else if (rd && (paddr == OFS_INT_STAT)) begin
            int_stat_q <= (int_stat_q & ~prdata[INT_W-1:0]) | ev;
        end else begin
            int_stat_q <= int_stat_q | ev;
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_cnf_timeout;
        en_q && (state_q == ST_CONF_ON) && tif.done && !conf_s;
    endsequence

    sequence s_fault_held;
        brake_fault_out && !brake_release_out;
    endsequence

    property p_rel_running;
        @(posedge clk) disable iff (!rst_b)
        $rose(brake_release_out) |-> $past(run_cmd);
    endproperty
    a_rel_running: assert property (p_rel_running) else $error("release without run"); // [R1]

    property p_fault_excl;
        @(posedge clk) disable iff (!rst_b)
        brake_fault_out |-> !brake_release_out && !accel_hold_out;
    endproperty
    a_fault_excl: assert property (p_fault_excl) else $error("fault with release"); // [R2]

    property p_rel_after_delay;
        @(posedge clk) disable iff (!rst_b)
        $rose(brake_release_out) |-> $past(state_q) == ST_REL_DLY && $past(tif.done);
    endproperty
    a_rel_after_delay: assert property (p_rel_after_delay) else $error("release early"); // [R3]

    property p_acc_after_conf;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_CONF_ON && conf_s && en_q) |=> accel_hold_out && state_q == ST_ACC_DLY;
    endproperty
    a_acc_after_conf: assert property (p_acc_after_conf) else $error("no accel hold"); // [R4]

    property p_stop_wait;
        @(posedge clk) disable iff (!rst_b)
        $fell(decel_hold_out) && en_q |-> $past(state_q) == ST_STP_DLY || brake_fault_out;
    endproperty
    a_stop_wait: assert property (p_stop_wait) else $error("stop hold ended early"); // [R5]

    property p_cnf_fault;
        @(posedge clk) disable iff (!rst_b)
        s_cnf_timeout |=> s_fault_held or !en_q;
    endproperty
    a_cnf_fault: assert property (p_cnf_fault) else $error("no fault on timeout"); // [R6]

    property p_rel_freq;
        @(posedge clk) disable iff (!rst_b)
        $rose(brake_release_out) |-> $past(out_freq) >= $past(rel_freq_q);
    endproperty
    a_rel_freq: assert property (p_rel_freq) else $error("release below frequency"); // [R7]

    property p_rel_current;
        @(posedge clk) disable iff (!rst_b)
        $rose(brake_release_out) |-> $past(out_current_pct) > $past(rel_cur_q);
    endproperty
    a_rel_current: assert property (p_rel_current) else $error("release below current"); // [R8]

    property p_disabled;
        @(posedge clk) disable iff (!rst_b)
        !en_q ##1 !en_q |-> !brake_release_out && !brake_fault_out && !accel_hold_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("output while disabled"); // [R9]

endmodule
`default_nettype wire

// [verif/ebs_brake_model.sv]
// Behavioural external brake with a confirmation contact.
// Assumes release_in comes from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ebs_brake_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic release_in,
    input wire logic [7:0] dly,
    input wire logic stuck,
    output logic confirm
);
    logic [7:0] cnt_q;
    // ----------------------------------------
    // Contact follows the command
    // ----------------------------------------
    // Confirm within window
    // A stuck brake never moves, so the sequencer must trip on its own
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            confirm <= 1'b0;
            cnt_q <= 8'h00;
        end else if (confirm != release_in && !stuck) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q >= dly) begin
                confirm <= release_in;
                cnt_q <= 8'h00;
            end
        end else begin
            cnt_q <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// [verif/ebs_top_tb_top.sv]
// Self-checking bench for the brake sequencer.
// Assumes the brake model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module ebs_top_tb_top;
    import ebs_pkg::*;
    localparam int TK = 4;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, run_cmd, stuck, conf;
    logic rel, flt, acch, dech, irq;
    logic [7:0] paddr, cur, mdly;
    logic [15:0] freq;
    logic [31:0] pwdata, prdata, rd, seed;
    int checks, n_mismatch, cyc, n, wr, wa, ws, wc;

    ebs_top #(.TICK_CYCLES(TK)) u_ebs_top (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
        .out_freq(freq), .out_current_pct(cur), .brake_confirm_in(conf),
        .brake_release_out(rel), .brake_fault_out(flt), .accel_hold_out(acch),
        .decel_hold_out(dech), .irq(irq));
    ebs_brake_model u_ebs_brake_model (.clk(clk), .rst_b(rst_b), .release_in(rel),
        .dly(mdly), .stuck(stuck), .confirm(conf));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int rnd_wait();
        seed = lfsr(seed);
        rnd_wait = 1 + int'(seed[1:0]);
    endfunction
    task automatic chk(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] mask,
                        input logic [31:0] exp, input string msg);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk((q & mask) === exp && e === 1'b0, msg);
    endtask
    // Cycles until a watched output reaches a level, capped at max
    task automatic wait_lvl(input int sel, input logic val, input int max, output int k);
        logic v;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            case (sel)
                0: v = rel;
                1: v = flt;
                2: v = acch;
                3: v = dech;
                default: v = conf;
            endcase
        end while (v !== val && k < max);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic e;
        seed = 32'h04AECEE9;
        {rst_b, psel, penable, pwrite, run_cmd, stuck} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        freq = 16'h0000;
        cur = 8'h00;
        mdly = 8'h05;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rreg(OFS_REL_CUR, 32'hFFFFFFFF, 32'h64, "rel_cur reset");
        rreg(OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl reset");
        apb(1'b0, 8'h30, 32'h0, rd, e);
        chk(rd === 32'h0 && e === 1'b1, "unmapped read");
        wreg(OFS_WAIT_REL, 32'h000003FF);
        rreg(OFS_WAIT_REL, 32'hFFFFFFFF, {23'h0, WAIT_MAX}, "wait clip");
        // Disabled: running must not touch the brake
        run_cmd <= 1'b1;
        freq <= 16'h2000;
        cur <= 8'hC0;
        wait_lvl(0, 1'b1, 40, n);
        chk(rel === 1'b0 && flt === 1'b0 && acch === 1'b0, "release while disabled");
        run_cmd <= 1'b0;
        $display("test reset_disabled done");

        wr = rnd_wait();
        wa = rnd_wait();
        ws = rnd_wait();
        wreg(OFS_WAIT_REL, wr);
        wreg(OFS_WAIT_ACC, wa);
        wreg(OFS_WAIT_STP, ws);
        wreg(OFS_WAIT_CNF, 32'd20);
        wreg(OFS_REL_FREQ, 32'd1000);
        wreg(OFS_REL_CUR, 32'd50);
        wreg(OFS_INT_MASK, 32'h7);
        freq <= 16'd999;
        cur <= 8'd51;
        wreg(OFS_CTRL, 32'h1);
        run_cmd <= 1'b1;
        wait_lvl(0, 1'b1, 40, n);
        chk(rel === 1'b0 && acch === 1'b1, "release below frequency");
        freq <= 16'd1000;
        wait_lvl(0, 1'b1, 200, n);
        chk(n >= wr * TK + 2 && n <= wr * TK + 8, "release delay");
        chk(irq === 1'b1, "irq on release");
        rreg(OFS_INT_STAT, 32'h1, 32'h1, "release event");
        @(posedge clk);
        chk(irq === 1'b0, "irq after read clear");
        wait_lvl(4, 1'b1, 200, n);
        wait_lvl(2, 1'b0, 200, n);
        chk(n >= wa * TK + 3 && n <= wa * TK + 9, "accel hold");
        run_cmd <= 1'b0;
        wait_lvl(0, 1'b0, 4, n);
        chk(rel === 1'b0 && dech === 1'b1, "release on stop");
        wait_lvl(4, 1'b0, 200, n);
        wait_lvl(3, 1'b0, 200, n);
        chk(n >= ws * TK + 3 && n <= ws * TK + 9, "stop delay");
        chk(flt === 1'b0, "fault with good brake");
        $display("test run_stop done");

        wc = rnd_wait();
        wreg(OFS_INT_MASK, 32'h0);
        wreg(OFS_WAIT_CNF, wc);
        stuck <= 1'b1;
        cur <= 8'd50;
        run_cmd <= 1'b1;
        wait_lvl(0, 1'b1, 60, n);
        chk(rel === 1'b0, "release at current limit");
        cur <= 8'd51;
        wait_lvl(0, 1'b1, 5, n);
        chk(rel === 1'b1, "release above current");
        wait_lvl(1, 1'b1, 200, n);
        chk(n >= wc * TK + 2 && n <= wc * TK + 7, "confirm timeout");
        chk(rel === 1'b0 && irq === 1'b0, "trip state");
        rreg(OFS_STATUS, 32'h000001FF, 32'h00000088, "status in trip");
        rreg(OFS_INT_STAT, 32'h4, 32'h4, "fault event");
        wreg(OFS_CTRL, 32'h3);
        wait_lvl(1, 1'b0, 4, n);
        chk(flt === 1'b0, "fault clear");
        run_cmd <= 1'b0;
        stuck <= 1'b0;
        $display("test fault done");
        final_report();
    end
endmodule
`default_nettype wire
